// ===== common/uel_pkg.sv
// Shared constants and carrier types for the user error code logger.
// Assumes one 125 MHz clock and a scan strobe from the program sequencer.
package uel_pkg;

  // System word placement of the error code table and annunciator map
  localparam int unsigned ERROR_TABLE_FIRST_WORD = 16;
  localparam int unsigned ERROR_TABLE_LAST_WORD  = 33;
  localparam int unsigned ANNUNCIATOR_FIRST_WORD = 34;
  localparam int unsigned ANNUNCIATOR_LAST_WORD  = 37;

  // Code range, table depth and message size
  localparam int unsigned CODE_MIN      = 1;
  localparam int unsigned CODE_MAX      = 64;
  localparam int unsigned TABLE_DEPTH   = 16;
  localparam int unsigned MSG_WORDS     = 6;
  localparam int unsigned MSG_CHARS     = 12;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned CODE_W        = 7;
  localparam int unsigned COUNT_W       = 5;
  localparam int unsigned IDX_W         = 4;

  // Reset values
  localparam logic [COUNT_W-1:0]  COUNT_RST = 5'h00;
  localparam logic [CODE_MAX-1:0] ANN_RST   = 64'h0;
  localparam logic [CODE_W-1:0]   CODE_RST  = 7'h00;

  // Twelve characters, two per word, first word at the message operand
  typedef logic [MSG_WORDS-1:0][WORD_W-1:0] uel_msg_t;

  // One instruction request as presented by the ladder program
  typedef struct packed {
    logic                enable;   // Instruction input, ON = 1
    logic [WORD_W-1:0]   code;     // Error code operand
    uel_msg_t            message;  // Six message registers
  } uel_req_t;

  // Recorded entry as seen by the host link
  typedef struct packed {
    logic [CODE_W-1:0]   code;
    uel_msg_t            message;
  } uel_entry_t;

endpackage

// ===== src/uel_error_logger.sv
// User error code logger: table, annunciator map, counter and error output.
// Assumes scanTick pulses once per program scan with the request valid.
`timescale 1ns/1ns

module uel_error_logger #(
  parameter int unsigned DEPTH = uel_pkg::TABLE_DEPTH
) (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // Scan timing and instruction request
  input  wire logic                           scanTick,
  input  wire uel_pkg::uel_req_t              logReq,
  // Instruction output
  output logic                                errorOut,
  // State for system words and host link
  output logic [uel_pkg::COUNT_W-1:0]         regCount,
  output logic [uel_pkg::CODE_MAX-1:0]        annMap,
  output uel_pkg::uel_entry_t                 firstEntry,
  input  wire logic [uel_pkg::IDX_W-1:0]      tableIdx,
  output logic [uel_pkg::CODE_W-1:0]          tableCode
);

  // Code range check, used by the registration path and the checks
  function automatic logic codeInRange(input logic [uel_pkg::WORD_W-1:0] c);
    codeInRange = (c >= 16'(uel_pkg::CODE_MIN)) &&
                  (c <= 16'(uel_pkg::CODE_MAX));
  endfunction

  logic                        inputPrev_q;
  logic                        errorOut_q;
  logic [uel_pkg::COUNT_W-1:0] count_q;
  logic [uel_pkg::CODE_MAX-1:0] ann_q;
  logic [uel_pkg::CODE_W-1:0]  codeTable_q [DEPTH];
  uel_pkg::uel_msg_t           msgTable_q  [DEPTH];
  uel_pkg::uel_entry_t         first_q;
  logic [uel_pkg::CODE_W-1:0]  tableCode_q;
  logic                        risingEdge;
  logic                        tableFull;
  logic                        doStore;
  logic [uel_pkg::IDX_W-1:0]   slot;

  // Edge is judged scan to scan, never cycle to cycle
  // A held input between scans must not look like a fresh edge
  assign risingEdge = scanTick && logReq.enable && !inputPrev_q;
  assign tableFull  = count_q >= uel_pkg::COUNT_W'(DEPTH);
  assign doStore    = risingEdge && !tableFull &&
                      codeInRange(logReq.code);
  assign slot       = count_q[uel_pkg::IDX_W-1:0];

  // Previous input level, sampled once per scan
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inputPrev_q <= 1'b0;
    end else if (scanTick) begin
      inputPrev_q <= logReq.enable;
    end
  end

  // Error output, re-evaluated each scan and held for the whole scan
  // A held-ON input reports error every scan; a program that wants only
  // the edge result must feed the input through a one-scan contact
  always_ff @(posedge core_clk) begin
    if (rst) begin
      errorOut_q <= 1'b0;
    end else if (scanTick) begin
      if (!logReq.enable) begin
        errorOut_q <= 1'b0;
      end else if (!inputPrev_q) begin
        errorOut_q <= !doStore;
      end else begin
        errorOut_q <= 1'b1;
      end
    end
  end

  // Registration counter; saturates because full tables refuse storing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= uel_pkg::COUNT_RST;
    end else if (doStore) begin
      count_q <= count_q + 5'h01;
    end
  end

  // Table slot after the last entry takes the code and message
  // No reset on the table: unused slots are masked on read instead,
  // which keeps the memory free of a wide reset fan-out
  always_ff @(posedge core_clk) begin
    if (doStore) begin
      codeTable_q[slot] <= logReq.code[uel_pkg::CODE_W-1:0];
      msgTable_q[slot]  <= logReq.message;
    end
  end

  // Annunciator map, code n lands on bit n-1
  // Bits 15:0 make up the first annunciator word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ann_q <= uel_pkg::ANN_RST;
    end else if (doStore) begin
      ann_q[logReq.code[5:0] - 6'h01] <= 1'b1;
    end
  end

  // Earliest entry is frozen once captured so the host sees a stable copy
  // A zero counter marks the first store; later stores leave it alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      first_q <= '0;
    end else if (doStore && (count_q == uel_pkg::COUNT_RST)) begin
      first_q.code    <= logReq.code[uel_pkg::CODE_W-1:0];
      first_q.message <= logReq.message;
    end
  end

  // Host-side table read, one cycle latency; unused slots read zero
  // Gating on the counter hides stale slots left over from before a reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tableCode_q <= uel_pkg::CODE_RST;
    end else if (uel_pkg::COUNT_W'(tableIdx) < count_q) begin
      tableCode_q <= codeTable_q[tableIdx];
    end else begin
      tableCode_q <= uel_pkg::CODE_RST;
    end
  end

  assign errorOut   = errorOut_q;
  assign regCount   = count_q;
  assign annMap     = ann_q;
  assign firstEntry = first_q;
  assign tableCode  = tableCode_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  idle_error_off_a: assert property (
    scanTick && !logReq.enable |=> !errorOut && $stable(regCount))
    else $error("error output not OFF while input OFF");

  bad_code_a: assert property (
    risingEdge && !codeInRange(logReq.code)
      |=> errorOut && $stable(regCount) && $stable(annMap))
    else $error("out-of-range code was not refused");

  full_table_a: assert property (
    risingEdge && (regCount >= 5'h10)
      |=> errorOut && $stable(regCount)
          ##1 ($stable(errorOut) || $past(scanTick)))
    else $error("full table did not raise error");

  good_store_a: assert property (
    doStore |=> !errorOut && (regCount == $past(regCount) + 5'h01))
    else $error("accepted code did not register cleanly");

  ann_bit_a: assert property (
    doStore |=> annMap[$past(logReq.code[5:0]) - 6'h01])
    else $error("annunciator bit not set for code");

  held_input_a: assert property (
    scanTick && logReq.enable && inputPrev_q
      |=> errorOut && $stable(regCount))
    else $error("held input re-executed or error OFF");

  slot_order_a: assert property (
    doStore |=> codeTable_q[$past(slot)] ==
                $past(logReq.code[uel_pkg::CODE_W-1:0]))
    else $error("code not stored after last entry");

  count_cap_a: assert property (
    regCount <= 5'h10)
    else $error("registration counter exceeded table depth");

  first_kept_a: assert property (
    doStore && (regCount != 5'h00) |=> $stable(firstEntry))
    else $error("first entry overwritten");

  first_msg_a: assert property (
    doStore && (regCount == 5'h00)
      |=> firstEntry.message == $past(logReq.message))
    else $error("message not captured with first code");

  read_unused_a: assert property (
    uel_pkg::COUNT_W'(tableIdx) >= regCount
      |=> tableCode == uel_pkg::CODE_RST)
    else $error("unused table slot did not read zero");

  no_store_hold_a: assert property (
    !doStore |=> $stable(regCount) && $stable(annMap))
    else $error("counter or map changed without a store");

  error_scan_a: assert property (
    !scanTick |=> $stable(errorOut))
    else $error("error output changed inside a scan");

  first_code_a: assert property (
    doStore && (regCount == 5'h00)
      |=> firstEntry.code == $past(logReq.code[uel_pkg::CODE_W-1:0]))
    else $error("first code not kept for host");

  store_cov_c:  cover property (doStore ##[1:50] doStore);
  full_cov_c:   cover property (risingEdge && tableFull);
  held_cov_c:   cover property (risingEdge ##[1:20] scanTick && inputPrev_q);
  range_cov_c:  cover property (risingEdge && !codeInRange(logReq.code));
  first_cov_c:  cover property (doStore && (count_q == uel_pkg::COUNT_RST));

endmodule

// ===== sim/uel_scan_seq.sv
// Scan sequencer model standing in for the ladder program's scan pacing.
// Assumes the bench samples scanTick on the rising edge of core_clk.
`timescale 1ns/1ns
module uel_scan_seq #(
  parameter int unsigned GAP = 2
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Scan strobe
  output logic      scanTick
);
  int unsigned cntQ = 0;
  initial scanTick = 1'b0;
  // One pulse every GAP cycles; driven just after the edge like the bench
  always @(posedge core_clk) begin
    cntQ <= #1 (rst || cntQ == GAP - 1) ? 0 : cntQ + 1;
    scanTick <= #1 !rst && cntQ == GAP - 1;
  end
endmodule

// ===== sim/user_error_code_logger_test.sv
// Self-checking bench for the user error code logger.
// Assumes the scan sequencer model paces every request.
`timescale 1ns/1ns
module user_error_code_logger_test;
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic                scanTick;
  uel_pkg::uel_req_t   logReq = '0;
  logic [3:0]          tableIdx = 4'h0;
  logic                errorOut;
  logic [4:0]          regCount;
  logic [63:0]         annMap;
  uel_pkg::uel_entry_t firstEntry;
  uel_pkg::uel_entry_t expFirst = '0;
  logic [6:0]          tableCode;
  logic [6:0]          tbl [16];
  logic [63:0]         expAnn = '0;
  logic                prevEn = 1'b0;
  logic                expErr;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  cnt = 0;
  int                  seed = 32'hde41a588;

  always #4 core_clk = ~core_clk;

  uel_scan_seq u_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .scanTick (scanTick)
  );

  uel_error_logger u_dut (
    .core_clk   (core_clk),
    .rst        (rst),
    .scanTick   (scanTick),
    .logReq     (logReq),
    .errorOut   (errorOut),
    .regCount   (regCount),
    .annMap     (annMap),
    .firstEntry (firstEntry),
    .tableIdx   (tableIdx),
    .tableCode  (tableCode)
  );

  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected error output of one scan, straight from the truth table
  function automatic logic expectErr(input logic en, input logic prev,
                                     input logic [15:0] c, input int n);
    if (!en) return 1'b0;
    if (prev) return 1'b1;
    return (c < 16'h0001) || (c > 16'h0040) || (n >= 16);
  endfunction

  // Hold one request until a scan takes it, then compare at +1
  task automatic op(input logic en, input logic [15:0] c);
    int w;
    logReq.enable = en;
    logReq.code = c;
    logReq.message = {$random(seed), $random(seed), $random(seed)};
    w = 0;
    do @(posedge core_clk); while (scanTick !== 1'b1 && ++w < 9);
    expErr = expectErr(en, prevEn, c, cnt);
    if (en && !prevEn && !expErr) begin
      tbl[cnt] = c[6:0];
      expAnn[c - 1] = 1'b1;
      if (cnt == 0) expFirst = {c[6:0], logReq.message};
      cnt++;
    end
    prevEn = en;
    #1;
    chk(errorOut, expErr);
    chk(regCount, cnt);
    chk(annMap, expAnn);
    chk(firstEntry, expFirst);
  endtask

  // Corner codes first, then 160 random requests, then a forced fill of the table
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    op(1'b1, 16'h0000);
    op(1'b0, 16'h0040);
    op(1'b1, 16'h0040);
    op(1'b1, 16'h0002);
    op(1'b0, 16'h0041);
    op(1'b1, 16'h0041);
    op(1'b0, 16'h0001);
    op(1'b1, 16'h0001);
    op(1'b0, 16'h0000);
    op(1'b1, 16'h0081);
    repeat (160) op(1'($random(seed) & 1), 16'($unsigned($random(seed)) % 72));
    // Fill the table for sure, then keep knocking on it while full
    repeat (20) begin
      op(1'b0, 16'h0003);
      op(1'b1, 16'h0010);
    end
    for (int i = 0; i < 16; i++) begin
      tableIdx = 4'(i);
      @(posedge core_clk);
      #1 chk(tableCode, i < cnt ? tbl[i] : 7'h00);
    end
    // Mid-run reset clears the log; the first store after it is fresh
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(errorOut, 1'b0);
    chk(regCount, 5'h00);
    chk(annMap, 64'h0);
    chk(firstEntry, '0);
    chk(tableCode, 7'h00);
    cnt = 0;
    expAnn = '0;
    expFirst = '0;
    prevEn = 1'b0;
    op(1'b1, 16'h0005);
    end_sim();
  end

  // Hang guard well beyond the expected few hundred cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule
